//--- inc/rbm_defines.vh
// Purpose: Constants for the reset and bus mode control block
// Assumes: APB word registers, 32-bit data, one clock pclk at 50 MHz
// Notes: Included once by the design through its guard
//
// Notes on behaviour
// - The reset request passes two synchroniser flops before anything uses it.
// - Memory inhibit stays asserted for the whole time the device is in reset.
// - Internal reset lasts 128 more clocks after the synchronised request negates.
// - During internal reset three-state outputs float; memory inhibit asserts, the others drive inactive.
// - After reset, bus outputs float until grant; then the first cycle starts.
// - Cache, translation straps and interrupt lines are sampled as the synchronised reset request negates.
// - Busy, in-progress and driven acknowledge go inactive before they float.
// - Reset ends any running cycle as acknowledged and resets internal state.
// - Software reset command pulses reset-out for 512 clocks, registers untouched.
// - A reset request during the reset-out pulse resets at once, ends reset-out.
// - Modes picked during reset stay fixed until the next reset.
// - Three driver groups pick strong or weak drive from their level line.
// - Cache strap low during reset turns on multiplexed address/data mode.
// - Multiplexed mode drives address in the first clock, data after it.
// - Translation strap low during reset turns on read latch strobe mode.
// - In strobe mode a latch holds read data while strobe low; edge flop follows.
// - The strobe only affects read capture, never bus termination.
// - With strobe mode off the latch is always transparent.
`ifndef RBM_DEFINES_VH
`define RBM_DEFINES_VH

// Register byte offsets
`define RBM_CONTROL_OFS      12'h000
`define RBM_STATUS_OFS       12'h004
`define RBM_MODES_OFS        12'h008

// Control fields
`define RBM_CTRL_SWRST_BIT   0

// Status fields
`define RBM_STAT_INTRST_BIT  0
`define RBM_STAT_SYSTEM_RESET_OUT_N_BIT    1
`define RBM_STAT_WAITGNT_BIT 2
`define RBM_STAT_MI_BIT      3

// Mode fields
`define RBM_MODE_MUX_BIT     0
`define RBM_MODE_LATCH_BIT   1
`define RBM_MODE_DRV_LSB     2
`define RBM_MODE_LVL_LSB     5

// Reset values
`define RBM_MODES_RST        3'h0
`define RBM_LEVELS_RST       3'h7
`define RBM_OE_RST           3'h7

// Timing counts in pclk cycles (last count value, period minus one)
`define RBM_STRETCH_LAST     8'h7F
`define RBM_SYSTEM_RESET_OUT_N_LAST        9'h1FF

`endif

//--- verif/rbm_ext_sys.sv
// Purpose: Board reset circuit and bus arbiter beside the block
// Assumes: Driven from the bench through its two tasks
// Notes: Straps return to idle well inside the reset stretch
`timescale 1ns/10ps
module rbm_ext_sys (
  input  wire       pclk,
  input  wire       system_reset_out_n,
  output reg        reset_request_in_n,
  output reg        cache_off_strap_n,
  output reg        translation_off_strap_n,
  output reg  [2:0] interrupt_level_lines,
  output reg        bus_grant_n,
  output wire       system_reset_n
);
  // One board reset covers both sources
  assign system_reset_n = reset_request_in_n & system_reset_out_n;
  // Power comes up with the request held
  initial begin
    reset_request_in_n = 1'b0;
    cache_off_strap_n = 1'b1;
    translation_off_strap_n = 1'b1;
    interrupt_level_lines = 3'h7;
    bus_grant_n = 1'b1;
  end
  // Never shorter than ten clocks, whatever the caller asks
  task hold_reset(input logic c, input logic t, input logic [2:0] l, input integer n);
    begin
      cache_off_strap_n <= c;
      translation_off_strap_n <= t;
      interrupt_level_lines <= l;
      bus_grant_n <= 1'b1;
      reset_request_in_n <= 1'b0;
      repeat (n < 10 ? 10 : n) @(posedge pclk);
      reset_request_in_n <= 1'b1;
      repeat (40) @(posedge pclk);
      cache_off_strap_n <= 1'b1;
      translation_off_strap_n <= 1'b1;
      interrupt_level_lines <= 3'h7;
    end
  endtask
  // Grant after a prompt or slow delay
  task grant(input integer d);
    begin
      repeat (d) @(posedge pclk);
      bus_grant_n <= 1'b0;
    end
  endtask
endmodule // rbm_ext_sys

//--- verif/rbm_reset_mode_ctrl_properties.sv
// Purpose: Port checks for reset sequencing, reset-out and bus modes
// Assumes: One clock domain, bound to every instance of the block
// Notes: Stretch window allows slack for the two synchroniser stages
`timescale 1ns/10ps
module rbm_check (
  input logic        pclk,
  input logic        presetn,
  input logic        reset_request_in_n,
  input logic        system_reset_out_n,
  input logic        memory_inhibit_n,
  input logic        bus_grant_n,
  input logic        core_cycle_start,
  input logic        core_reset,
  input logic        core_first_cycle_go,
  input logic        bus_busy_n_out,
  input logic        bus_busy_n_oe_n,
  input logic        transfer_in_progress_n_oe_n,
  input logic        address_oe_n,
  input logic        data_oe_n,
  input logic        mux_bus_mode,
  input logic        latch_strobe_mode,
  input logic [2:0]  group_strong_drive,
  input logic        read_latch_strobe,
  input logic [31:0] read_data_in,
  input logic [31:0] read_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] hi_cnt;
  logic [9:0] lo_cnt;
  // Length counters; too long a run for a repetition operator
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 10'h000;
      lo_cnt <= 10'h000;
    end else begin
      hi_cnt <= (reset_request_in_n && core_reset) ? hi_cnt + 10'h001 : 10'h000;
      lo_cnt <= system_reset_out_n ? 10'h000 : lo_cnt + 10'h001;
    end
  end
  a_sync_two_stage: assert property ($fell(reset_request_in_n) && !core_reset |=>
    !core_reset ##[0:2] core_reset)
    else $error("reset request not synchronised");
  a_inhibit_reset: assert property (core_reset |-> !memory_inhibit_n)
    else $error("memory inhibit released in reset");
  a_stretch_length: assert property ($fell(core_reset) |-> hi_cnt >= 10'h080 && hi_cnt <= 10'h086)
    else $error("internal reset stretch wrong");
  a_quiet_reset: assert property (core_reset [*3] |->
    bus_busy_n_oe_n && transfer_in_progress_n_oe_n && address_oe_n && data_oe_n)
    else $error("output driven during reset");
  a_go_after_grant: assert property (core_first_cycle_go |-> !$past(bus_grant_n) && memory_inhibit_n)
    else $error("first cycle without grant");
  a_busy_negate_first: assert property ($rose(bus_busy_n_oe_n) && !reset_request_in_n |->
    $past(bus_busy_n_out))
    else $error("bus busy floated while asserted");
  a_system_reset_out_n_length: assert property ($rose(system_reset_out_n) && !core_reset |-> lo_cnt == 10'h200)
    else $error("reset-out pulse length wrong");
  a_system_reset_out_n_abort: assert property ($fell(reset_request_in_n) && !system_reset_out_n |-> ##[1:4] system_reset_out_n)
    else $error("reset-out not ended by request");
  a_modes_fixed: assert property (!core_reset && !$past(core_reset) |->
    $stable(mux_bus_mode) && $stable(latch_strobe_mode) && $stable(group_strong_drive))
    else $error("mode changed outside reset");
  a_mux_addr_first: assert property (mux_bus_mode && !address_oe_n |-> core_cycle_start && data_oe_n)
    else $error("multiplexed address phase wrong");
  a_latch_hold: assert property (latch_strobe_mode && !read_latch_strobe && !$past(read_latch_strobe) |=>
    $stable(read_data))
    else $error("read latch not holding");
  a_latch_clear: assert property (!latch_strobe_mode |=> read_data == $past(read_data_in))
    else $error("read latch not transparent");
  c_system_reset_out_n_pulse: cover property ($rose(system_reset_out_n) && !core_reset);
  c_first_go: cover property (core_first_cycle_go);
  c_latch_held: cover property (latch_strobe_mode && !read_latch_strobe);
endmodule // rbm_check

bind rbm_reset_mode_ctrl rbm_check rbm_check_i (.pclk, .presetn, .reset_request_in_n, .system_reset_out_n,
  .memory_inhibit_n, .bus_grant_n, .core_cycle_start, .core_reset, .core_first_cycle_go, .bus_busy_n_out,
  .bus_busy_n_oe_n, .transfer_in_progress_n_oe_n, .address_oe_n, .data_oe_n, .mux_bus_mode, .latch_strobe_mode,
  .group_strong_drive, .read_latch_strobe, .read_data_in, .read_data);

//--- verif/rbm_reset_mode_ctrl_tb_top.sv
// Purpose: Directed bench for reset sequencing, modes and reset-out
// Assumes: Zero-wait APB slave, pclk at 50 MHz
// Notes: Exact pulse and stretch lengths are left to the checker
`timescale 1ns/10ps
`include "rbm_defines.vh"
module rbm_reset_mode_ctrl_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, read_data_in = 32'h0, rd;
  logic core_own_bus = 1'b0, core_cycle_start = 1'b0, core_cycle_active = 1'b0, core_cycle_write = 1'b0;
  logic core_snoop_ack_drive = 1'b0, core_snoop_ack = 1'b0, core_reset_instr = 1'b0, read_latch_strobe = 1'b1;
  wire pready, pslverr, reset_request_in_n, system_reset_out_n, memory_inhibit_n, cache_off_strap_n;
  wire translation_off_strap_n, bus_grant_n, core_reset, core_cycle_force_end, core_first_cycle_go, system_reset_n;
  wire bus_busy_n_out, bus_busy_n_oe_n, transfer_in_progress_n_out, transfer_in_progress_n_oe_n;
  wire transfer_ack_n_out, transfer_ack_n_oe_n, address_oe_n, data_oe_n, mux_bus_mode, latch_strobe_mode;
  wire [2:0] interrupt_level_lines, group_strong_drive;
  wire [31:0] prdata, read_data;
  integer bad_count = 0, cmp_count = 0;
  rbm_reset_mode_ctrl rbm_reset_mode_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .reset_request_in_n, .system_reset_out_n, .memory_inhibit_n, .cache_off_strap_n,
    .translation_off_strap_n, .interrupt_level_lines, .bus_grant_n, .core_own_bus, .core_cycle_start,
    .core_cycle_active, .core_cycle_write, .core_snoop_ack_drive, .core_snoop_ack, .core_reset_instr, .core_reset,
    .core_cycle_force_end, .core_first_cycle_go, .bus_busy_n_in(1'b1), .bus_busy_n_out, .bus_busy_n_oe_n,
    .transfer_in_progress_n_in(1'b1), .transfer_in_progress_n_out, .transfer_in_progress_n_oe_n,
    .transfer_ack_n_in(1'b1), .transfer_ack_n_out, .transfer_ack_n_oe_n, .address_oe_n, .data_oe_n, .mux_bus_mode,
    .latch_strobe_mode, .group_strong_drive, .read_latch_strobe, .read_data_in, .read_data);
  rbm_ext_sys rbm_ext_sys_i (.pclk, .system_reset_out_n, .reset_request_in_n, .cache_off_strap_n,
    .translation_off_strap_n, .interrupt_level_lines, .bus_grant_n, .system_reset_n);
  // 20 ns period
  always #10 pclk = ~pclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    begin
      chk({31'h0, got}, {31'h0, exp});
    end
  endtask
  // Request held until pready is seen at an edge; data and error taken there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task test_done;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Run takes about 1000 clocks
  initial begin
    #200000;
    bad_count = bad_count + 1;
    test_done;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rbm_ext_sys_i.hold_reset(1'b0, 1'b0, 3'h2, 12);
    chk_bit(memory_inhibit_n, 1'b0);
    while (core_reset !== 1'b0) @(posedge pclk);
    apb(1'b0, `RBM_STATUS_OFS, 32'h0);
    chk(rd, (32'h1 << `RBM_STAT_WAITGNT_BIT) | (32'h1 << `RBM_STAT_MI_BIT));
    chk({29'h0, group_strong_drive}, {29'h0, ~3'h2});
    apb(1'b0, `RBM_MODES_OFS, 32'h0);
    chk(rd, {24'h0, 3'h2, ~3'h2, 2'b11});
    rbm_ext_sys_i.grant(7);
    while (core_first_cycle_go !== 1'b1) @(posedge pclk);
    #1;
    chk_bit(memory_inhibit_n, 1'b1);
    @(posedge pclk);
    core_own_bus <= 1'b1;
    core_cycle_active <= 1'b1;
    core_cycle_write <= 1'b1;
    core_cycle_start <= 1'b1;
    #1;
    chk_bit(address_oe_n, 1'b0);
    @(posedge pclk);
    core_cycle_start <= 1'b0;
    #1;
    chk({30'h0, address_oe_n, data_oe_n}, 32'h2);
    @(posedge pclk);
    read_data_in <= 32'hA5A50001;
    @(posedge pclk);
    read_data_in <= 32'h5A5A0002;
    read_latch_strobe <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk(read_data, 32'hA5A50001);
    @(posedge pclk);
    read_latch_strobe <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b1, `RBM_CONTROL_OFS, 32'h1);
    chk(read_data, 32'h5A5A0002);
    apb(1'b0, `RBM_STATUS_OFS, 32'h0);
    chk(rd, 32'h1 << `RBM_STAT_SYSTEM_RESET_OUT_N_BIT);
    apb(1'b0, `RBM_MODES_OFS, 32'h0);
    chk(rd, {24'h0, 3'h2, ~3'h2, 2'b11});
    chk_bit(system_reset_n, 1'b0);
    repeat (520) @(posedge pclk);
    chk_bit(system_reset_out_n, 1'b1);
    core_reset_instr <= 1'b1;
    core_snoop_ack_drive <= 1'b1;
    core_snoop_ack <= 1'b1;
    @(posedge pclk);
    core_reset_instr <= 1'b0;
    repeat (100) @(posedge pclk);
    chk_bit(system_reset_out_n, 1'b0);
    fork
      rbm_ext_sys_i.hold_reset(1'b1, 1'b1, 3'h7, 12);
      begin
        repeat (3) @(posedge pclk);
        #1;
        chk_bit(core_cycle_force_end, 1'b1);
        @(posedge pclk);
        #1;
        chk({30'h0, transfer_ack_n_out, transfer_ack_n_oe_n}, 32'h2);
        @(posedge pclk);
        #1;
        chk({30'h0, system_reset_out_n, core_reset}, 32'h3);
      end
    join
    core_own_bus <= 1'b0;
    core_cycle_active <= 1'b0;
    core_snoop_ack_drive <= 1'b0;
    while (core_reset !== 1'b0) @(posedge pclk);
    read_latch_strobe <= 1'b0;
    read_data_in <= 32'h0F0F0003;
    apb(1'b1, `RBM_MODES_OFS, 32'hFFFFFFFF);
    chk(read_data, 32'h0F0F0003);
    apb(1'b0, `RBM_MODES_OFS, 32'h0);
    chk(rd, {24'h0, 3'h7, 5'h00});
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, err}, 32'h1);
    test_done;
  end
endmodule // rbm_reset_mode_ctrl_tb_top

//--- verilog/rbm_reset_mode_ctrl.v
// Purpose: Reset sequencing, strap-selected bus modes and reset-out pulse
// Assumes: All pin inputs synchronous to pclk except the reset request
// Notes: APB slave with zero wait states; no interrupt logic
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "rbm_defines.vh"

module rbm_reset_mode_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Reset pins
  input  wire        reset_request_in_n,
  output reg         system_reset_out_n,
  output reg         memory_inhibit_n,
  // Mode straps and level lines
  input  wire        cache_off_strap_n,
  input  wire        translation_off_strap_n,
  input  wire [2:0]  interrupt_level_lines,
  // Arbitration
  input  wire        bus_grant_n,
  // Core side
  input  wire        core_own_bus,
  input  wire        core_cycle_start,
  input  wire        core_cycle_active,
  input  wire        core_cycle_write,
  input  wire        core_snoop_ack_drive,
  input  wire        core_snoop_ack,
  input  wire        core_reset_instr,
  output reg         core_reset,
  output reg         core_cycle_force_end,
  output reg         core_first_cycle_go,
  // Bus control pins, three signals each
  input  wire        bus_busy_n_in,
  output wire        bus_busy_n_out,
  output wire        bus_busy_n_oe_n,
  input  wire        transfer_in_progress_n_in,
  output wire        transfer_in_progress_n_out,
  output wire        transfer_in_progress_n_oe_n,
  input  wire        transfer_ack_n_in,
  output wire        transfer_ack_n_out,
  output wire        transfer_ack_n_oe_n,
  // Address and data driver enables
  output wire        address_oe_n,
  output wire        data_oe_n,
  // Mode outputs
  output reg         mux_bus_mode,
  output reg         latch_strobe_mode,
  output reg  [2:0]  group_strong_drive,
  // Read data path
  input  wire        read_latch_strobe,
  input  wire [31:0] read_data_in,
  output reg  [31:0] read_data
);

  // Address decode for the error answer only; the read mux has its own case
  function rbm_hit;
    input [11:0] addr;
    begin
      rbm_hit = (addr == `RBM_CONTROL_OFS) || (addr == `RBM_STATUS_OFS) ||
                (addr == `RBM_MODES_OFS);
    end
  endfunction

  reg        req_meta;
  reg        req_sync;
  reg        req_prev;
  reg        int_rst;
  reg        int_rst_prev;
  reg  [7:0] stretch_cnt;
  reg        system_reset_out_n_active;
  reg  [8:0] system_reset_out_n_cnt;
  reg        wait_grant;
  reg        bus_enabled;
  reg  [2:0] sampled_levels;
  reg  [2:0] drv_out;
  reg  [2:0] drv_oe_n;
  reg  [31:0] hold_data;
  reg  [31:0] next_prdata;
  wire       req_rise;
  wire       rst_entry;
  wire       sw_cmd;
  wire       apb_write;
  wire       strobe_holding;
  wire [31:0] latch_a;
  wire [2:0] want_drive;
  wire [2:0] want_value;

  // Two flops before use; first flop feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_prev <= 1'b0;
    end else begin
      req_meta <= reset_request_in_n;
      req_sync <= req_meta;
      req_prev <= req_sync;
    end
  end

  // Release edge of the synchronised request
  assign req_rise  = req_sync & ~req_prev;
  // Next edge puts the device into reset
  assign rst_entry = ~req_sync & ~int_rst;

  // Internal reset stretch; a new request restarts the count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_rst      <= 1'b1;
      int_rst_prev <= 1'b1;
      stretch_cnt  <= 8'h00;
    end else begin
      int_rst_prev <= int_rst;
      if (!req_sync) begin
        int_rst     <= 1'b1;
        stretch_cnt <= 8'h00;
      end else if (int_rst) begin
        if (stretch_cnt == `RBM_STRETCH_LAST) begin
          int_rst <= 1'b0;
        end else begin
          stretch_cnt <= stretch_cnt + 8'h01;
        end
      end
    end
  end

  // Straps caught at the release edge, then frozen until next reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_bus_mode       <= 1'b0;
      latch_strobe_mode  <= 1'b0;
      sampled_levels     <= `RBM_LEVELS_RST;
      group_strong_drive <= `RBM_MODES_RST;
    end else if (req_rise) begin
      mux_bus_mode       <= ~cache_off_strap_n;
      latch_strobe_mode  <= ~translation_off_strap_n;
      sampled_levels     <= interrupt_level_lines;
      group_strong_drive <= ~interrupt_level_lines;
    end
  end
  // Modes hold: nothing else writes them

  // APB access phase write; zero wait states
  assign apb_write = psel & penable & pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~rbm_hit(paddr);
  assign sw_cmd    = apb_write & (paddr == `RBM_CONTROL_OFS) & pwdata[`RBM_CTRL_SWRST_BIT];

  // Reset-out pulse; software command or core instruction starts it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_reset_out_n_active        <= 1'b0;
      system_reset_out_n_cnt           <= 9'h000;
      system_reset_out_n <= 1'b1;
    end else begin
      if (!req_sync || int_rst) begin
        system_reset_out_n_active        <= 1'b0;
        system_reset_out_n_cnt           <= 9'h000;
        system_reset_out_n <= 1'b1;
      end else if (system_reset_out_n_active) begin
        if (system_reset_out_n_cnt == `RBM_SYSTEM_RESET_OUT_N_LAST) begin
          system_reset_out_n_active        <= 1'b0;
          system_reset_out_n <= 1'b1;
        end else begin
          system_reset_out_n_cnt <= system_reset_out_n_cnt + 9'h001;
        end
      end else if (sw_cmd || core_reset_instr) begin
        // Only the pin pulses; no internal state is touched here
        system_reset_out_n_active        <= 1'b1;
        system_reset_out_n_cnt           <= 9'h000;
        system_reset_out_n <= 1'b0;
      end
    end
  end

  // Reset to core, forced cycle end, grant wait and memory inhibit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset           <= 1'b1;
      core_cycle_force_end <= 1'b0;
      core_first_cycle_go  <= 1'b0;
      wait_grant           <= 1'b0;
      bus_enabled          <= 1'b0;
      memory_inhibit_n     <= 1'b0;
    end else begin
      core_reset           <= int_rst | ~req_sync;
      core_cycle_force_end <= rst_entry & core_cycle_active;
      core_first_cycle_go  <= 1'b0;
      if (int_rst || !req_sync) begin
        wait_grant       <= 1'b0;
        bus_enabled      <= 1'b0;
        memory_inhibit_n <= 1'b0;
      end else if (int_rst_prev) begin
        wait_grant <= 1'b1;
      end else if (wait_grant && !bus_grant_n) begin
        // Outputs stay floating until this grant
        wait_grant          <= 1'b0;
        bus_enabled         <= 1'b1;
        core_first_cycle_go <= 1'b1;
        memory_inhibit_n    <= 1'b1;
      end
    end
  end

  // Order: busy, in-progress, acknowledge
  assign want_drive = {core_snoop_ack_drive, core_cycle_active, core_own_bus};
  assign want_value = {~core_snoop_ack, ~core_cycle_active, ~core_own_bus};

  // Control pins: on reset entry drive high one clock, then float
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_out  <= `RBM_OE_RST;
      drv_oe_n <= `RBM_OE_RST;
    end else if (int_rst) begin
      if (!int_rst_prev) begin
        drv_out <= 3'h7;
      end else begin
        drv_oe_n <= 3'h7;
      end
    end else if (bus_enabled) begin
      drv_out  <= want_value;
      drv_oe_n <= ~want_drive;
    end else begin
      drv_out  <= 3'h7;
      drv_oe_n <= 3'h7;
    end
  end

  assign bus_busy_n_out              = drv_out[0];
  assign bus_busy_n_oe_n             = drv_oe_n[0];
  assign transfer_in_progress_n_out  = drv_out[1];
  assign transfer_in_progress_n_oe_n = drv_oe_n[1];
  assign transfer_ack_n_out          = drv_out[2];
  assign transfer_ack_n_oe_n         = drv_oe_n[2];

  // Address only in the opening clock when multiplexed; data after it
  assign address_oe_n = ~(bus_enabled & ~int_rst &
                          (mux_bus_mode ? core_cycle_start : core_cycle_active));
  assign data_oe_n    = ~(bus_enabled & ~int_rst & core_cycle_active & core_cycle_write &
                          ~(mux_bus_mode & core_cycle_start));

  // Latch A model: holds only while strobe is low and strobe mode is on
  assign strobe_holding = latch_strobe_mode & ~read_latch_strobe;
  assign latch_a        = strobe_holding ? hold_data : read_data_in;

  // Hold register follows the bus while open; strobe never reaches termination
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_data <= 32'h00000000;
      read_data <= 32'h00000000;
    end else begin
      if (!strobe_holding) begin
        hold_data <= read_data_in;
      end
      read_data <= latch_a;
    end
  end

  // Read mux, captured in the setup phase
  always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
      `RBM_STATUS_OFS: begin
        next_prdata[`RBM_STAT_INTRST_BIT]  = int_rst;
        next_prdata[`RBM_STAT_SYSTEM_RESET_OUT_N_BIT]    = system_reset_out_n_active;
        next_prdata[`RBM_STAT_WAITGNT_BIT] = wait_grant;
        next_prdata[`RBM_STAT_MI_BIT]      = ~memory_inhibit_n;
      end
      `RBM_MODES_OFS: begin
        next_prdata[`RBM_MODE_MUX_BIT]                    = mux_bus_mode;
        next_prdata[`RBM_MODE_LATCH_BIT]                  = latch_strobe_mode;
        next_prdata[`RBM_MODE_DRV_LSB+2:`RBM_MODE_DRV_LSB] = group_strong_drive;
        next_prdata[`RBM_MODE_LVL_LSB+2:`RBM_MODE_LVL_LSB] = sampled_levels;
      end
      `RBM_CONTROL_OFS: begin
        next_prdata[`RBM_CTRL_SWRST_BIT] = system_reset_out_n_active;
      end
      default: begin
        next_prdata = 32'h00000000;
      end
    endcase
  end

  // Read data registered so it is steady through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end

endmodule // rbm_reset_mode_ctrl
